// ===== htfc_bit_divider.sv
`timescale 1ns/10ps
module htfc_bit_divider #(
  parameter htfc_pkg::htfc_div_t DIV = htfc_pkg::htfc_div_t'(htfc_pkg::BIT_DIV)
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  import htfc_pkg::*;

  htfc_divs_s s;
  htfc_divs_s n;

  // ----------------------------------------
  // one-cycle enable every DIV clocks
  // ----------------------------------------
  always_comb begin
    n      = s;
    n.tick = 1'b0;
    if (s.cnt == DIV - 5'h01) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt  = s.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;

endmodule // htfc_bit_divider

// ===== htfc_far_end.sv
`timescale 1ns/10ps
module htfc_far_end (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           line_bit,
  input  wire logic                           line_vld,
  output logic                                rx_bit,
  output logic                                rx_stb,
  output logic [htfc_pkg::FRAME_BITS-1:0]     frame,
  output int                                  frames
);
  import htfc_pkg::*;
  logic [FRAME_BITS-1:0] shift_r;
  int                    idx_r;
  // ------
  // line side: whole frames, first bit in the msb
  // ------
  always @(posedge clk) begin
    if (rst) begin
      idx_r  <= 0;
      frames <= 0;
    end else if (line_vld) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], line_bit};
      idx_r   <= (idx_r == FRAME_BITS - 1) ? 0 : idx_r + 1;
      if (idx_r == FRAME_BITS - 1) begin
        frame  <= {shift_r[FRAME_BITS-2:0], line_bit};
        frames <= frames + 1;
      end
    end
  end
  // ------
  // upstream bits
  // ------
  initial begin
    rx_bit = 1'b0;
    rx_stb = 1'b0;
  end
  // data held one cycle past the strobe, then inverted so a late sample shows up
  task automatic send(input logic b);
    @(posedge clk);
    rx_bit <= b;
    rx_stb <= 1'b1;
    repeat (3) @(posedge clk);
    rx_stb <= 1'b0;
    @(posedge clk);
    rx_bit <= ~b;
    repeat (2) @(posedge clk);
  endtask
endmodule // htfc_far_end

// ===== htfc_pkg.sv
package htfc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ       = 40000;
  localparam int unsigned LINE_RATE_KHZ = 1552;
  // shortest legal bit period rounds the divider down
  localparam int unsigned BIT_DIV       = CLK_KHZ / LINE_RATE_KHZ;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_TX_FRAME_CONTROL  = 8'ha8;
  localparam logic [7:0] OFS_TX_SYNC_WORD_HEAD = 8'ha9;
  localparam logic [7:0] OFS_TX_SYNC_WORD_TAIL = 8'haa;
  localparam logic [7:0] OFS_RSVD_LO           = 8'hab;
  localparam logic [7:0] OFS_RSVD_HI           = 8'hb0;
  localparam logic [7:0] OFS_TX_OVERHEAD_ONE   = 8'hb1;
  localparam logic [7:0] OFS_TX_OVERHEAD_TWO   = 8'hb2;
  localparam logic [7:0] OFS_TX_OVERHEAD_THREE = 8'hb3;
  localparam logic [7:0] OFS_TX_OVERHEAD_FOUR  = 8'hb4;
  localparam logic [7:0] REG_RST               = 8'h00;

  // control field positions
  localparam int unsigned CTL_OVH_NML   = 7;
  localparam int unsigned CTL_RX_POLY   = 6;
  localparam int unsigned CTL_RX_SCR_EN = 5;
  localparam int unsigned CTL_TX_POLY   = 4;
  localparam int unsigned CTL_TX_SCR_EN = 3;
  localparam int unsigned CTL_SYNC_INH  = 2;
  localparam int unsigned CTL_SEND_ST   = 1;
  localparam int unsigned CTL_PAY_FRC   = 0;

  // ----------------------------------------
  // frame layout: sync, overhead, payload, stuff
  // ----------------------------------------
  localparam int unsigned SYNC_BITS   = 10;
  localparam int unsigned OVH_BITS    = 28;
  localparam int unsigned PAY_BITS    = 64;
  localparam int unsigned STUFF_BITS  = 4;
  localparam int unsigned OVH_START   = SYNC_BITS;
  localparam int unsigned PAY_START   = OVH_START + OVH_BITS;
  localparam int unsigned STUFF_START = PAY_START + PAY_BITS;
  localparam int unsigned FRAME_BITS  = STUFF_START + STUFF_BITS;

  // scrambler x^-23 taps (lfsr[0] is the newest bit)
  localparam int unsigned SCR_LEN     = 23;
  localparam int unsigned TAP_C2R     = 17;
  localparam int unsigned TAP_R2C     = 4;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [6:0] htfc_cnt_t;
  typedef logic [4:0] htfc_div_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] sw_head;
    logic [1:0] sw_tail;
    logic [7:0] ovh1;
    logic [7:0] ovh2;
    logic [7:0] ovh3;
    logic [7:0] ovh4;
  } htfc_regs_s;

  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] addr;
    logic [7:0] data;
  } htfc_upi_s;

  typedef struct packed {
    logic bit_v;
    logic stb;
  } htfc_rx_s;

  typedef struct packed {
    htfc_regs_s regs;
    htfc_regs_s snap;
    htfc_cnt_t  cnt;
    htfc_upi_s  upi1;
    htfc_upi_s  upi2;
    logic       wr_q;
    logic [7:0] rd_data;
    logic       data_oe;
    logic       line_bit;
    logic       line_vld;
    logic       take;
    htfc_rx_s   rx1;
    htfc_rx_s   rx2;
    logic       rx_stb_q;
    logic       rx_bit;
    logic       rx_vld;
  } htfc_top_s;

  typedef struct packed {
    logic [SCR_LEN-1:0] lfsr;
  } htfc_scr_s;

  typedef struct packed {
    htfc_div_t cnt;
    logic      tick;
  } htfc_divs_s;

  localparam htfc_regs_s REGS_RST = '{REG_RST, REG_RST, REG_RST[1:0], REG_RST, REG_RST, REG_RST, REG_RST};
  localparam htfc_upi_s  UPI_IDLE = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};

endpackage

// ===== htfc_scrambler.sv
`timescale 1ns/10ps
module htfc_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic step,
  input  wire logic enable,
  input  wire logic poly_r2c,
  input  wire logic din,
  output logic      dout
);
  import htfc_pkg::*;

  htfc_scr_s s;
  htfc_scr_s n;
  logic      fb;

  // ----------------------------------------
  // self-synchronising x^-23 scrambler
  // ----------------------------------------
  assign fb   = s.lfsr[SCR_LEN-1] ^ (poly_r2c ? s.lfsr[TAP_R2C] : s.lfsr[TAP_C2R]);
  assign dout = enable ? (din ^ fb) : din;

  // held while bypassed so re-enabling resumes from a known history
  always_comb begin
    n = s;
    if (step && enable) begin
      n.lfsr = {s.lfsr[SCR_LEN-2:0], (DESCRAMBLE ? din : dout)};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule // htfc_scrambler

// ===== htfc_tx_frame_ctrl.sv
`timescale 1ns/10ps
module htfc_tx_frame_ctrl (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       UP_CS_N,
  input  wire logic       UP_WR_N,
  input  wire logic       UP_RD_N,
  input  wire logic [7:0] UP_ADDR,
  input  wire logic [7:0] UP_DATA_I,
  output logic      [7:0] UP_DATA_O,
  output logic            UP_DATA_OE,
  input  wire logic       PAYLOAD_BIT,
  output logic            PAYLOAD_TAKE,
  output logic            TX_LINE_BIT,
  output logic            TX_LINE_VALID,
  input  wire logic       RX_LINE_BIT,
  input  wire logic       RX_BIT_STROBE,
  output logic            RX_DATA_BIT,
  output logic            RX_DATA_VALID
);
  import htfc_pkg::*;

  htfc_top_s  s;
  htfc_top_s  n;
  logic       bit_en;
  logic       wr_commit;
  logic       rx_step;
  htfc_regs_s src;
  logic [9:0] sync_word;
  logic [27:0] ovh_word;
  htfc_cnt_t  sync_idx;
  htfc_cnt_t  ovh_idx;
  htfc_cnt_t  stuff_idx;
  logic       cls_sync;
  logic       cls_ovh;
  logic       cls_pay;
  logic       cls_stuff;
  logic       pay_frc;
  logic       sync_frc;
  logic       ovh_frc;
  logic       pattern;
  logic       raw_bit;
  logic       plain_bit;
  logic       scr_out;
  logic       dscr_out;

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input htfc_regs_s r);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_TX_FRAME_CONTROL:  v = r.ctrl;
      OFS_TX_SYNC_WORD_HEAD: v = r.sw_head;
      OFS_TX_SYNC_WORD_TAIL: v = {6'h00, r.sw_tail};
      OFS_TX_OVERHEAD_ONE:   v = r.ovh1;
      OFS_TX_OVERHEAD_TWO:   v = r.ovh2;
      OFS_TX_OVERHEAD_THREE: v = r.ovh3;
      OFS_TX_OVERHEAD_FOUR:  v = r.ovh4;
      default:               v = 8'h00;   // reserved ABh..B0h and unmapped read zero
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // bit timing and scramblers
  // ----------------------------------------
  htfc_bit_divider u_div (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (bit_en)
  );

  htfc_scrambler #(.DESCRAMBLE(1'b0)) u_scr (
    .clk      (CLK_SYS),
    .rst      (RST),
    .step     (bit_en && !cls_sync),
    .enable   (src.ctrl[CTL_TX_SCR_EN]),
    .poly_r2c (src.ctrl[CTL_TX_POLY]),
    .din      (plain_bit),
    .dout     (scr_out)
  );

  htfc_scrambler #(.DESCRAMBLE(1'b1)) u_dscr (
    .clk      (CLK_SYS),
    .rst      (RST),
    .step     (rx_step),
    .enable   (s.regs.ctrl[CTL_RX_SCR_EN]),
    .poly_r2c (s.regs.ctrl[CTL_RX_POLY]),
    .din      (s.rx2.bit_v),
    .dout     (dscr_out)
  );

  // ----------------------------------------
  // frame bit selection
  // ----------------------------------------
  // first bit of a frame reads live registers; the rest read the snapshot
  assign src       = (s.cnt == '0) ? s.regs : s.snap;
  assign sync_word = {src.sw_head, src.sw_tail};
  assign ovh_word  = {src.ovh1, src.ovh2, src.ovh3, src.ovh4[7:4]};
  assign sync_idx  = htfc_cnt_t'(SYNC_BITS - 1) - s.cnt;
  assign ovh_idx   = htfc_cnt_t'(PAY_START - 1) - s.cnt;
  assign stuff_idx = htfc_cnt_t'(FRAME_BITS - 1) - s.cnt;
  assign cls_sync  = s.cnt < htfc_cnt_t'(OVH_START);
  assign cls_ovh   = !cls_sync && s.cnt < htfc_cnt_t'(PAY_START);
  assign cls_pay   = !cls_sync && !cls_ovh && s.cnt < htfc_cnt_t'(STUFF_START);
  assign cls_stuff = s.cnt >= htfc_cnt_t'(STUFF_START);

  assign pay_frc   = src.ctrl[CTL_PAY_FRC];
  assign sync_frc  = pay_frc && src.ctrl[CTL_SYNC_INH];
  assign ovh_frc   = pay_frc && (src.ctrl[CTL_SYNC_INH] || !src.ctrl[CTL_OVH_NML]);
  assign pattern   = src.ctrl[CTL_SEND_ST];

  always_comb begin
    raw_bit = PAYLOAD_BIT;
    if (cls_sync) begin
      raw_bit = sync_word[sync_idx[3:0]];
    end else if (cls_ovh) begin
      raw_bit = ovh_word[ovh_idx[4:0]];
    end else if (cls_stuff) begin
      raw_bit = src.ovh4[stuff_idx[1:0]];
    end
  end

  assign plain_bit = ((cls_sync || cls_stuff) && sync_frc) || (cls_ovh && ovh_frc) || (cls_pay && pay_frc)
                     ? pattern : raw_bit;

  // ----------------------------------------
  // processor port
  // ----------------------------------------
  // write commits on the rising edge of the strobe; data must be held past it
  assign wr_commit = !s.upi2.cs_n && s.upi2.wr_n && !s.wr_q;
  assign rx_step   = s.rx2.stb && !s.rx_stb_q;

  always_comb begin
    n        = s;
    n.upi1   = '{UP_CS_N, UP_WR_N, UP_RD_N, UP_ADDR, UP_DATA_I};
    n.upi2   = s.upi1;
    n.wr_q   = s.upi2.wr_n;
    if (wr_commit) begin
      unique case (s.upi2.addr)
        OFS_TX_FRAME_CONTROL:  n.regs.ctrl    = s.upi2.data;
        OFS_TX_SYNC_WORD_HEAD: n.regs.sw_head = s.upi2.data;
        OFS_TX_SYNC_WORD_TAIL: n.regs.sw_tail = s.upi2.data[1:0];   // upper bits dropped
        OFS_TX_OVERHEAD_ONE:   n.regs.ovh1    = s.upi2.data;
        OFS_TX_OVERHEAD_TWO:   n.regs.ovh2    = s.upi2.data;
        OFS_TX_OVERHEAD_THREE: n.regs.ovh3    = s.upi2.data;
        OFS_TX_OVERHEAD_FOUR:  n.regs.ovh4    = s.upi2.data;
        default:               n.regs         = s.regs;   // reserved writes ignored
      endcase
    end
    n.data_oe = !s.upi2.cs_n && !s.upi2.rd_n;
    n.rd_data = rd_mux(s.upi2.addr, s.regs);

    // transmit frame
    n.line_vld = 1'b0;
    n.take     = 1'b0;
    if (bit_en) begin
      if (s.cnt == '0) begin
        n.snap = s.regs;
      end
      n.line_bit = cls_sync ? plain_bit : scr_out;   // sync word never scrambled
      n.line_vld = 1'b1;
      n.take     = cls_pay;
      n.cnt      = (s.cnt == htfc_cnt_t'(FRAME_BITS - 1)) ? '0 : s.cnt + 7'h01;
    end

    // receive descrambler path
    n.rx1      = '{RX_LINE_BIT, RX_BIT_STROBE};
    n.rx2      = s.rx1;
    n.rx_stb_q = s.rx2.stb;
    n.rx_vld   = rx_step;
    if (rx_step) begin
      n.rx_bit = dscr_out;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s      <= '0;
      s.regs <= REGS_RST;
      s.snap <= REGS_RST;
      s.upi1 <= UPI_IDLE;
      s.upi2 <= UPI_IDLE;
      s.wr_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign UP_DATA_O     = s.rd_data;
  assign UP_DATA_OE    = s.data_oe;
  assign PAYLOAD_TAKE  = s.take;
  assign TX_LINE_BIT   = s.line_bit;
  assign TX_LINE_VALID = s.line_vld;
  assign RX_DATA_BIT   = s.rx_bit;
  assign RX_DATA_VALID = s.rx_vld;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_ovh_forced;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && cls_ovh && src.ctrl[CTL_PAY_FRC] && !src.ctrl[CTL_OVH_NML] && !src.ctrl[CTL_TX_SCR_EN]
      |=> TX_LINE_BIT == $past(src.ctrl[CTL_SEND_ST]);
  endproperty
  a_ovh_forced: assert property (p_ovh_forced) else $error("overhead not forced");

  property p_sync_forced;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && cls_sync && src.ctrl[CTL_PAY_FRC] && src.ctrl[CTL_SYNC_INH]
      |=> TX_LINE_VALID && TX_LINE_BIT == $past(src.ctrl[CTL_SEND_ST]);
  endproperty
  a_sync_forced: assert property (p_sync_forced) else $error("sync word not forced");

  property p_pay_forced;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && cls_pay && src.ctrl[CTL_PAY_FRC] && !src.ctrl[CTL_TX_SCR_EN]
      |=> PAYLOAD_TAKE && TX_LINE_BIT == $past(src.ctrl[CTL_SEND_ST]);
  endproperty
  a_pay_forced: assert property (p_pay_forced) else $error("payload not forced");

  property p_all_normal;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && !src.ctrl[CTL_PAY_FRC] && !src.ctrl[CTL_TX_SCR_EN] && (cls_pay || cls_ovh)
      |=> TX_LINE_BIT == $past(raw_bit);
  endproperty
  a_all_normal: assert property (p_all_normal) else $error("normal data altered");

  property p_sync_first;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && s.cnt == '0 && !(s.regs.ctrl[CTL_PAY_FRC] && s.regs.ctrl[CTL_SYNC_INH])
      |=> TX_LINE_BIT == $past(s.regs.sw_head[7]);
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("sync word msb not first");

  property p_sync_last;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && s.cnt == htfc_cnt_t'(SYNC_BITS - 1) && !sync_frc
      |=> TX_LINE_BIT == $past(s.snap.sw_tail[0]);
  endproperty
  a_sync_last: assert property (p_sync_last) else $error("sync tail bit 0 not last");

  property p_snap_hold;
    @(posedge CLK_SYS) disable iff (RST)
    !(bit_en && s.cnt == '0) |=> $stable(s.snap);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed mid frame");

  property p_rsvd_write;
    @(posedge CLK_SYS) disable iff (RST)
    wr_commit && s.upi2.addr >= OFS_RSVD_LO && s.upi2.addr <= OFS_RSVD_HI |=> $stable(s.regs);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed state");

  property p_dscr_bypass;
    @(posedge CLK_SYS) disable iff (RST)
    rx_step && !s.regs.ctrl[CTL_RX_SCR_EN] |=> RX_DATA_VALID && RX_DATA_BIT == $past(s.rx2.bit_v);
  endproperty
  a_dscr_bypass: assert property (p_dscr_bypass) else $error("descrambler not bypassed");

  property p_stuff_forced;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && cls_stuff && sync_frc && !src.ctrl[CTL_TX_SCR_EN]
      |=> TX_LINE_BIT == $past(src.ctrl[CTL_SEND_ST]);
  endproperty
  a_stuff_forced: assert property (p_stuff_forced) else $error("stuff bits not forced");

  property p_ovh_first;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && s.cnt == htfc_cnt_t'(OVH_START) && !ovh_frc && !src.ctrl[CTL_TX_SCR_EN]
      |=> TX_LINE_BIT == $past(s.snap.ovh1[7]);
  endproperty
  a_ovh_first: assert property (p_ovh_first) else $error("overhead one bit 7 not first");

  property p_stuff_first;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en && s.cnt == htfc_cnt_t'(STUFF_START) && !sync_frc && !src.ctrl[CTL_TX_SCR_EN]
      |=> TX_LINE_BIT == $past(s.snap.ovh4[3]);
  endproperty
  a_stuff_first: assert property (p_stuff_first) else $error("stuff bit one not first");

  property p_take_pay;
    @(posedge CLK_SYS) disable iff (RST)
    bit_en |=> TX_LINE_VALID && PAYLOAD_TAKE == $past(cls_pay);
  endproperty
  a_take_pay: assert property (p_take_pay) else $error("payload take outside payload");

  property p_rsvd_read;
    @(posedge CLK_SYS) disable iff (RST)
    !s.upi2.cs_n && !s.upi2.rd_n && s.upi2.addr >= OFS_RSVD_LO && s.upi2.addr <= OFS_RSVD_HI
      |=> UP_DATA_OE && UP_DATA_O == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");

  c_sync_forced: cover property (@(posedge CLK_SYS) disable iff (RST) bit_en && cls_sync && sync_frc);
  c_pay_forced:  cover property (@(posedge CLK_SYS) disable iff (RST) bit_en && cls_pay && pay_frc);
  c_reg_write:   cover property (@(posedge CLK_SYS) disable iff (RST) wr_commit);
  c_rx_step:     cover property (@(posedge CLK_SYS) disable iff (RST) rx_step);

endmodule // htfc_tx_frame_ctrl

// ===== htfc_tx_frame_ctrl_tb.sv
`timescale 1ns/10ps
module htfc_tx_frame_ctrl_tb;
  import htfc_pkg::*;
  logic         clk_sys;
  logic         rst;
  logic         up_cs_n;
  logic         up_wr_n;
  logic         up_rd_n;
  logic [7:0]   up_addr;
  logic [7:0]   up_data_i;
  logic [7:0]   up_data_o;
  logic         up_data_oe;
  logic         payload_bit;
  logic         payload_take;
  logic         tx_line_bit;
  logic         tx_line_valid;
  logic         rx_line_bit;
  logic         rx_bit_strobe;
  logic         rx_data_bit;
  logic         rx_data_valid;
  logic [105:0] frame;
  int           frames;
  logic [47:0]  rx_got;
  int           failures;
  int           checks_done;
  logic [7:0]   ofs_tab [7] = '{OFS_TX_FRAME_CONTROL, OFS_TX_SYNC_WORD_HEAD, OFS_TX_SYNC_WORD_TAIL,
                                OFS_TX_OVERHEAD_ONE, OFS_TX_OVERHEAD_TWO, OFS_TX_OVERHEAD_THREE, OFS_TX_OVERHEAD_FOUR};
  logic [7:0]   val_tab [7] = '{8'h80, 8'h3c, 8'h02, 8'h5a, 8'hc3, 8'h96, 8'he1};
  logic [7:0]   ctl_tab [9] = '{8'h80, 8'h00, 8'h81, 8'h83, 8'h01, 8'h03, 8'h07, 8'h85, 8'h84};

  htfc_tx_frame_ctrl i_htfc_tx_frame_ctrl (
    .CLK_SYS(clk_sys), .RST(rst), .UP_CS_N(up_cs_n), .UP_WR_N(up_wr_n), .UP_RD_N(up_rd_n),
    .UP_ADDR(up_addr), .UP_DATA_I(up_data_i), .UP_DATA_O(up_data_o), .UP_DATA_OE(up_data_oe),
    .PAYLOAD_BIT(payload_bit), .PAYLOAD_TAKE(payload_take), .TX_LINE_BIT(tx_line_bit),
    .TX_LINE_VALID(tx_line_valid), .RX_LINE_BIT(rx_line_bit), .RX_BIT_STROBE(rx_bit_strobe),
    .RX_DATA_BIT(rx_data_bit), .RX_DATA_VALID(rx_data_valid));
  htfc_far_end i_htfc_far_end (
    .clk(clk_sys), .rst(rst), .line_bit(tx_line_bit), .line_vld(tx_line_valid),
    .rx_bit(rx_line_bit), .rx_stb(rx_bit_strobe), .frame(frame), .frames(frames));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ------
  // payload source toggles per bit, so normal payload alternates
  // ------
  always @(posedge clk_sys) begin
    if (rst) begin
      payload_bit <= 1'b0;
      rx_got      <= 48'h0;
    end else begin
      if (payload_take === 1'b1)
        payload_bit <= ~payload_bit;
      if (rx_data_valid === 1'b1)
        rx_got <= {rx_got[46:0], rx_data_bit};
    end
  end
  // ------
  // helpers
  // ------
  task automatic check(input logic [105:0] seen, input logic [105:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    up_cs_n   <= 1'b0;
    up_addr   <= a;
    up_data_i <= d;
    up_wr_n   <= 1'b0;
    repeat (4) @(posedge clk_sys);
    up_wr_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    up_cs_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(posedge clk_sys);
    up_cs_n <= 1'b0;
    up_addr <= a;
    up_rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (up_data_oe !== 1'b1 && n < 10);
    check(106'({up_data_oe, up_data_o}), 106'({1'b1, e}));
    up_cs_n <= 1'b1;
    up_rd_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic upto(input int tgt);
    for (int n = 0; n < 6000 && frames < tgt; n++)
      @(posedge clk_sys);
    if (frames < tgt)
      failures++;
  endtask
  // two boundaries, so the frame seen was sampled after the last write
  task automatic grab;
    upto(frames + 2);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    for (int k = 0; k < 7; k++)
      rchk(ofs_tab[k], 8'h00);
    for (int k = 0; k < 7; k++)
      wr(ofs_tab[k], val_tab[k]);
    wr(OFS_RSVD_LO, 8'hff);
    wr(OFS_RSVD_HI, 8'hff);
    for (int k = 0; k < 7; k++)
      rchk(ofs_tab[k], val_tab[k]);
    rchk(OFS_RSVD_LO, 8'h00);
    rchk(OFS_RSVD_HI, 8'h00);
    rchk(8'hae, 8'h00);
  endtask
  task automatic t_force;
    logic [7:0] c;
    logic       st;
    logic       pf;
    logic       sf;
    logic       of;
    logic [63:0] pay;
    for (int k = 0; k < 9; k++) begin
      c  = ctl_tab[k];
      st = c[CTL_SEND_ST];
      pf = c[CTL_PAY_FRC];
      sf = pf & c[CTL_SYNC_INH];
      of = pf & (c[CTL_SYNC_INH] | ~c[CTL_OVH_NML]);
      wr(OFS_TX_FRAME_CONTROL, c);
      grab();
      check(106'(frame[105:96]), 106'(sf ? {10{st}} : {8'h3c, 2'b10}));
      check(106'(frame[95:68]),
            106'(of ? {28{st}} : {8'h5a, 8'hc3, 8'h96, 4'he}));
      check(106'(frame[3:0]), 106'(sf ? {4{st}} : 4'h1));
      pay = pf ? frame[67:4] : frame[67:4] ^ {frame[66:4], ~frame[4]};
      check(106'(pay), 106'(pf ? {64{st}} : {64{1'b1}}));
    end
  endtask
  task automatic t_snap;
    int f0;
    wr(OFS_TX_FRAME_CONTROL, 8'h80);
    grab();
    f0 = frames;
    repeat (40) @(posedge clk_sys);
    wr(OFS_TX_OVERHEAD_ONE, 8'h81);
    upto(f0 + 1);
    check(106'(frame[95:88]), 106'h5a);
    upto(f0 + 2);
    check(106'(frame[95:88]), 106'h81);
  endtask
  task automatic t_scram;
    logic [63:0] fold;
    int          tap;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_TX_FRAME_CONTROL, k ? 8'h9b : 8'h8b);
      grab();
      tap = k ? TAP_R2C + 1 : TAP_C2R + 1;
      for (int i = 4; i < 68; i++)
        fold[i-4] = frame[i] ^ frame[i+tap] ^ frame[i+SCR_LEN];
      check(106'(fold), 106'({64{1'b1}}));
      check(106'(frame[105:96]), 106'({8'h3c, 2'b10}));
    end
  endtask
  task automatic t_rx;
    logic [47:0] seq;
    logic [47:0] exp;
    logic [7:0]  c;
    int          tap;
    seq = 48'h9c3b_e51a_6f27;
    for (int k = 0; k < 3; k++) begin
      c   = (k == 0) ? 8'h20 : (k == 1) ? 8'h60 : 8'h00;
      tap = (k == 1) ? TAP_R2C + 1 : TAP_C2R + 1;
      wr(OFS_TX_FRAME_CONTROL, c);
      for (int n = 0; n < 48; n++)
        i_htfc_far_end.send(seq[n]);
      repeat (8) @(posedge clk_sys);
      for (int n = 23; n < 48; n++)
        exp[47-n] = (k == 2) ? seq[n] : seq[n] ^ seq[n-tap] ^ seq[n-SCR_LEN];
      check(106'(rx_got[24:0]), 106'(exp[24:0]));
    end
  endtask
  // ------
  // main sequence and watchdog
  // ------
  initial begin
    failures    = 0;
    checks_done = 0;
    rst         = 1'b1;
    up_cs_n     = 1'b1;
    up_wr_n     = 1'b1;
    up_rd_n     = 1'b1;
    up_addr     = 8'h00;
    up_data_i   = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_force();
    t_snap();
    t_scram();
    t_rx();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule // htfc_tx_frame_ctrl_tb
